// >>> core/ipss_pkg.sv
// Purpose: shared constants and types for the address source selector
// Assumes: switch bank of ten bits, index 0 = web switch, 9 = mode switch
// Notes: addresses are packed as four octets, most significant first
package ipss_pkg;
  // ----------------------------------------------------------------
  // network parameter carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] ip;
    logic [31:0] mask;
    logic [31:0] gw;
  } ipss_net_type;

  // ----------------------------------------------------------------
  // switch positions and factory values
  // ----------------------------------------------------------------
  localparam int SW_WEB = 0;
  localparam int SW_MODE = 9;
  localparam logic [31:0] DEF_IP = 32'hc0a801fe;
  localparam logic [31:0] DEF_MASK = 32'hffffff00;
  localparam logic [31:0] DEF_GW = 32'hc0a80101;
  localparam logic [7:0] OCT_ZERO = 8'h00;
  localparam logic [7:0] OCT_BCAST = 8'hff;
  localparam logic [3:0] SEL_DHCP = 4'h1;
  localparam logic [3:0] SEL_BOOTP = 4'h2;
  localparam logic [3:0] SEL_STORED = 4'h4;
  localparam logic [3:0] SEL_ONCE = 4'h8;

  // ----------------------------------------------------------------
  // modes and states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_DEFAULT = 3'b000,
    MODE_DIRECT = 3'b001,
    MODE_DHCP = 3'b010,
    MODE_BOOTP = 3'b011,
    MODE_STORED = 3'b100,
    MODE_ONCE = 3'b101
  } ipss_mode_type;

  typedef enum logic [1:0] {
    ST_SAMPLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } ipss_state_type;
endpackage

// >>> core/ipss_top.sv
// Purpose: picks the source of ip, mask and gateway at power-up
// Assumes: srst_i is the power-on reset; switches static around release
// Notes: nonvolatile store and server clients are outside this block
`timescale 1ns/1ns
module ipss_top
  import ipss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // configuration switches
  input wire logic [9:0] dip_i,
  // planning tool project parameters and download event
  input wire ipss_net_type proj_i,
  input wire logic dl_valid_i,
  // nonvolatile store contents and persistent flag
  input wire ipss_net_type nv_i,
  input wire logic nv_flag_i,
  // server answers
  input wire ipss_net_type srv_i,
  input wire logic srv_valid_i,
  // applied parameters and status
  output ipss_net_type net_o,
  output logic net_valid_o,
  output ipss_mode_type mode_o,
  output logic web_en_o,
  // server requests
  output logic dhcp_req_o,
  output logic bootp_req_o,
  // nonvolatile writes
  output ipss_net_type nv_wdata_o,
  output logic nv_we_o,
  output logic nv_flag_set_o,
  output logic nv_flag_clr_o
);
  // ----------------------------------------------------------------
  // switch decode
  // ----------------------------------------------------------------
  ipss_state_type state_r, state_nxt;
  ipss_mode_type mode_r;
  logic [9:0] dip_r;
  logic sampled_r;

  wire [7:0] low_byte = dip_r[8:1];
  wire [3:0] sel = dip_r[4:1];
  wire mode_sw = dip_r[SW_MODE];
  // switches 1 to 8 carry binary weights in switch order
  wire byte_ok = (low_byte != OCT_ZERO) && (low_byte != OCT_BCAST);
  ipss_mode_type dec_mode;
  assign dec_mode =
    !mode_sw ? (byte_ok ? MODE_DIRECT : MODE_DEFAULT) :
    (sel == SEL_DHCP) ? MODE_DHCP :
    (sel == SEL_BOOTP) ? MODE_BOOTP :
    (sel == SEL_STORED) ? MODE_STORED :
    (sel == SEL_ONCE) ? MODE_ONCE : MODE_DEFAULT;

  wire once_stored = (mode_r == MODE_ONCE) && nv_flag_i;
  wire need_srv = (mode_r == MODE_DHCP) || (mode_r == MODE_BOOTP) ||
    ((mode_r == MODE_ONCE) && !nv_flag_i);

  ipss_net_type def_net;
  assign def_net = '{ip: DEF_IP, mask: DEF_MASK, gw: DEF_GW};
  ipss_net_type direct_net;
  assign direct_net = '{ip: {proj_i.ip[31:8], low_byte},
                        mask: proj_i.mask, gw: proj_i.gw};

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  wire srv_done = (state_r == ST_WAIT) && srv_valid_i;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_SAMPLE: state_nxt = need_srv ? ST_WAIT : ST_RUN;
      ST_WAIT: if (srv_valid_i) begin
        state_nxt = ST_RUN;
      end
      ST_RUN: state_nxt = ST_RUN;
      default: state_nxt = ST_SAMPLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      dip_r <= 10'h000;
      sampled_r <= 1'b0;
      mode_r <= MODE_DEFAULT;
    end else if (!sampled_r) begin
      dip_r <= dip_i;
      sampled_r <= 1'b1;
    end else if (state_r == ST_SAMPLE && !net_valid_o &&
                 !nv_flag_clr_o && !dhcp_req_o && !bootp_req_o) begin
      mode_r <= dec_mode;
    end
  end

  // mode latches one cycle after the switches; hold sample state until then
  logic mode_ok_r;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_ok_r <= 1'b0;
      state_r <= ST_SAMPLE;
    end else begin
      mode_ok_r <= sampled_r;
      if (mode_ok_r) begin
        state_r <= state_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire start = mode_ok_r && (state_r == ST_SAMPLE);
  ipss_net_type pick_net;
  assign pick_net =
    (mode_r == MODE_DIRECT) ? direct_net :
    ((mode_r == MODE_STORED) || once_stored) ? nv_i : def_net;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      net_o <= '0;
      net_valid_o <= 1'b0;
      mode_o <= MODE_DEFAULT;
      web_en_o <= 1'b0;
      dhcp_req_o <= 1'b0;
      bootp_req_o <= 1'b0;
      nv_wdata_o <= '0;
      nv_we_o <= 1'b0;
      nv_flag_set_o <= 1'b0;
      nv_flag_clr_o <= 1'b0;
    end else begin
      nv_we_o <= 1'b0;
      nv_flag_set_o <= 1'b0;
      nv_flag_clr_o <= 1'b0;
      mode_o <= mode_r;
      web_en_o <= dip_r[SW_WEB];
      if (start) begin
        nv_flag_clr_o <= (mode_r != MODE_ONCE);
        dhcp_req_o <= (mode_r == MODE_DHCP) ||
          ((mode_r == MODE_ONCE) && !nv_flag_i);
        bootp_req_o <= (mode_r == MODE_BOOTP);
        if (!need_srv) begin
          net_o <= pick_net;
          net_valid_o <= 1'b1;
        end
      end
      if (srv_done) begin
        dhcp_req_o <= 1'b0;
        bootp_req_o <= 1'b0;
        net_o <= srv_i;
        net_valid_o <= 1'b1;
        if (mode_r == MODE_ONCE) begin
          nv_wdata_o <= srv_i;
          nv_we_o <= 1'b1;
          nv_flag_set_o <= 1'b1;
        end
      end
      if (dl_valid_i && state_r == ST_RUN) begin
        nv_wdata_o <= proj_i;
        nv_we_o <= 1'b1;
        net_valid_o <= 1'b1;
        net_o <= (mode_r == MODE_DIRECT) ? direct_net : proj_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_default;
    @(posedge clk_i) disable iff (srst_i)
      $rose(net_valid_o) && mode_o == MODE_DEFAULT |-> net_o == def_net;
  endproperty
  a_default: assert property (p_default) else $error("bad defaults");
  property p_direct;
    @(posedge clk_i) disable iff (srst_i)
      $rose(net_valid_o) && mode_o == MODE_DIRECT |->
        net_o.ip[7:0] == dip_r[8:1] && net_o.mask == $past(proj_i.mask);
  endproperty
  a_direct: assert property (p_direct) else $error("bad direct");
  property p_dhcp;
    @(posedge clk_i) disable iff (srst_i)
      $rose(dhcp_req_o) |-> mode_o == MODE_DHCP || mode_o == MODE_ONCE;
  endproperty
  a_dhcp: assert property (p_dhcp) else $error("bad dhcp req");
  property p_srv;
    @(posedge clk_i) disable iff (srst_i)
      srv_done |=> net_valid_o && net_o == $past(srv_i);
  endproperty
  a_srv: assert property (p_srv) else $error("server not applied");
  property p_bootp;
    @(posedge clk_i) disable iff (srst_i)
      bootp_req_o |-> mode_o == MODE_BOOTP && !dhcp_req_o;
  endproperty
  a_bootp: assert property (p_bootp) else $error("bad bootp req");
  property p_once;
    @(posedge clk_i) disable iff (srst_i)
      srv_done && mode_r == MODE_ONCE |=> nv_we_o && nv_flag_set_o;
  endproperty
  a_once: assert property (p_once) else $error("flag not set");
  property p_flag;
    @(posedge clk_i) disable iff (srst_i)
      start && mode_r == MODE_ONCE && nv_flag_i |=> !dhcp_req_o;
  endproperty
  a_flag: assert property (p_flag) else $error("needless dhcp");
  property p_clr;
    @(posedge clk_i) disable iff (srst_i)
      start && mode_r != MODE_ONCE |=> nv_flag_clr_o;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  property p_web;
    @(posedge clk_i) disable iff (srst_i)
      mode_ok_r |=> web_en_o == dip_r[SW_WEB];
  endproperty
  a_web: assert property (p_web) else $error("bad web gate");
  property p_hold;
    @(posedge clk_i) disable iff (srst_i)
      sampled_r |=> $stable(dip_r);
  endproperty
  a_hold: assert property (p_hold) else $error("switches resampled");
  property p_cfg;
    @(posedge clk_i) disable iff (srst_i)
      $rose(net_valid_o) && mode_o == MODE_DIRECT |->
        net_o.ip[31:8] == $past(proj_i.ip[31:8]) &&
        net_o.gw == $past(proj_i.gw);
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad project values");
  property p_stored;
    @(posedge clk_i) disable iff (srst_i)
      $rose(net_valid_o) && mode_o == MODE_STORED |-> net_o == $past(nv_i);
  endproperty
  a_stored: assert property (p_stored) else $error("not loaded");
  property p_dl;
    @(posedge clk_i) disable iff (srst_i)
      dl_valid_i && state_r == ST_RUN |=>
        nv_we_o && net_valid_o && nv_wdata_o == $past(proj_i);
  endproperty
  a_dl: assert property (p_dl) else $error("download not kept");
  property p_bans;
    @(posedge clk_i) disable iff (srst_i)
      srv_done && mode_r == MODE_BOOTP |=>
        !bootp_req_o && net_valid_o && net_o == $past(srv_i);
  endproperty
  a_bans: assert property (p_bans) else $error("bad bootp");
  property p_oreq;
    @(posedge clk_i) disable iff (srst_i)
      start && mode_r == MODE_ONCE && !nv_flag_i |=>
        dhcp_req_o && !net_valid_o;
  endproperty
  a_oreq: assert property (p_oreq) else $error("no request");
  property p_sel;
    @(posedge clk_i) disable iff (srst_i)
      mode_ok_r && mode_sw && $countones(sel) != 1 |-> mode_r == MODE_DEFAULT;
  endproperty
  a_sel: assert property (p_sel) else $error("bad select accepted");
  property p_resv;
    @(posedge clk_i) disable iff (srst_i)
      mode_ok_r && !mode_sw && (low_byte == OCT_ZERO || low_byte == OCT_BCAST)
        |-> mode_r == MODE_DEFAULT;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved byte");
  property p_ssel;
    @(posedge clk_i) disable iff (srst_i)
      mode_ok_r && mode_sw && sel == SEL_STORED |-> mode_r == MODE_STORED;
  endproperty
  a_ssel: assert property (p_ssel) else $error("stored not chosen");
  c_direct: cover property (@(posedge clk_i) mode_o == MODE_DIRECT);
  c_dhcp: cover property (@(posedge clk_i) srv_done);
  c_once: cover property (@(posedge clk_i) nv_flag_set_o);
  c_dl: cover property (@(posedge clk_i) dl_valid_i && state_r == ST_RUN);
  c_boot: cover property (@(posedge clk_i) srv_done && bootp_req_o);
endmodule

// >>> test/ipss_srv_model.sv
// Purpose: address server on the far side, answers one request per run-up
// Assumes: request stays high until the answer pulse is taken
// Notes: answer delay set by dly_i, 1 to 8 cycles after the request
`timescale 1ns/1ns
module ipss_srv_model
  import ipss_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // requests from the block
  input wire logic dhcp_req_i,
  input wire logic bootp_req_i,
  // answer timing and content
  input wire logic [2:0] dly_i,
  input wire ipss_net_type ans_i,
  // answer to the block
  output ipss_net_type srv_o,
  output logic srv_valid_o
);
  logic [3:0] cnt_r;
  logic done_r;
  logic tog_r;
  wire req = dhcp_req_i | bootp_req_i;
  wire hit = cnt_r == {1'b0, dly_i};
  // outside the pulse the lines keep moving, so a stale answer never passes
  assign srv_o = srv_valid_o ? ans_i :
    (tog_r ? ~ans_i : {ans_i[47:0], ans_i[95:48]});
  // ip, mask, gw as one answer
  always_ff @(posedge clk_i) begin
    tog_r <= srst_i ? 1'b0 : ~tog_r;
    if (srst_i || !req) begin
      cnt_r <= 4'h0;
      done_r <= 1'b0;
      srv_valid_o <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      srv_valid_o <= !done_r && hit;
      done_r <= done_r | hit;
    end
  end
endmodule

// >>> test/ipss_top_bench.sv
// Purpose: power-up source selection checked against a bench model
// Assumes: each case is a fresh power-on through srst_i
// Notes: switches are moved after sampling to prove they are ignored
`timescale 1ns/1ns
module ipss_top_bench;
  import ipss_pkg::*;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [9:0] dip_i = 10'h000;
  logic dl_valid_i = 1'b0;
  logic nv_flag_i = 1'b0;
  logic [2:0] dly = 3'h0;
  ipss_net_type proj_i = '0, nv_i = '0, ans = '0;
  ipss_net_type srv_i, net_o, nv_wdata_o;
  ipss_mode_type mode_o;
  logic srv_valid_i, net_valid_o, web_en_o, dhcp_req_o, bootp_req_o;
  logic nv_we_o, nv_flag_set_o, nv_flag_clr_o;
  logic [4:0] seen;
  int err_count = 0;
  int cmp_count = 0;
  // flag bit 10, switches 9..0
  localparam logic [10:0] TBL [13] = '{11'h001, 11'h000, 11'h024,
    11'h1fe, 11'h002, 11'h1fc, 11'h3e2, 11'h2a4, 11'h209, 11'h210,
    11'h610, 11'h206, 11'h200};
  always #20 clk_i = ~clk_i;
  ipss_top dut (.clk_i, .srst_i, .dip_i, .proj_i, .dl_valid_i, .nv_i,
    .nv_flag_i, .srv_i, .srv_valid_i, .net_o, .net_valid_o, .mode_o,
    .web_en_o, .dhcp_req_o, .bootp_req_o, .nv_wdata_o, .nv_we_o,
    .nv_flag_set_o, .nv_flag_clr_o);
  ipss_srv_model srv (.clk_i, .srst_i, .dhcp_req_i(dhcp_req_o),
    .bootp_req_i(bootp_req_o), .dly_i(dly), .ans_i(ans), .srv_o(srv_i),
    .srv_valid_o(srv_valid_i));
  // pulses are short, so they are gathered over the whole run-up
  always @(posedge clk_i)
    if (srst_i) seen <= 5'h00;
    else seen <= seen | {dhcp_req_o, bootp_req_o, nv_we_o,
      nv_flag_set_o, nv_flag_clr_o};
  task automatic finish_test();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk_net(input ipss_net_type e, input ipss_net_type g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t net %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_val(input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %0t value %h exp %h", $time, g, e);
    end
  endtask
  task automatic run(input logic [9:0] d, input logic f);
    ipss_mode_type m;
    ipss_net_type e;
    logic [7:0] b;
    logic once_new;
    int n;
    b = d[8:1];
    m = MODE_DEFAULT;
    if (!d[SW_MODE]) begin
      if (b != OCT_ZERO && b != OCT_BCAST) m = MODE_DIRECT;
    end else begin
      case (d[4:1])
        SEL_DHCP: m = MODE_DHCP;
        SEL_BOOTP: m = MODE_BOOTP;
        SEL_STORED: m = MODE_STORED;
        SEL_ONCE: m = MODE_ONCE;
        default: m = MODE_DEFAULT;
      endcase
    end
    once_new = m == MODE_ONCE && !f;
    @(posedge clk_i);
    srst_i <= 1'b1;
    dip_i <= d;
    nv_flag_i <= f;
    dly <= 3'($urandom);
    proj_i <= {$urandom, $urandom, $urandom};
    nv_i <= {$urandom, $urandom, $urandom};
    ans <= {$urandom, $urandom, $urandom};
    repeat (6) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    dip_i <= ~d;
    for (n = 0; n < 64 && net_valid_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    if (n == 64) begin
      err_count++;
      finish_test();
    end
    @(posedge clk_i);
    #1;
    e = {DEF_IP, DEF_MASK, DEF_GW};
    case (m)
      MODE_DIRECT: e = {proj_i.ip[31:8], b, proj_i.mask, proj_i.gw};
      MODE_DHCP, MODE_BOOTP: e = ans;
      MODE_STORED: e = nv_i;
      MODE_ONCE: e = f ? nv_i : ans;
      default: ;
    endcase
    chk_net(e, net_o);
    chk_val({5'h00, m}, {5'h00, mode_o});
    chk_val({7'h00, d[SW_WEB]}, {7'h00, web_en_o});
    chk_val({3'h0, m == MODE_DHCP || once_new, m == MODE_BOOTP, once_new,
      once_new, m != MODE_ONCE}, {3'h0, seen});
    if (once_new) chk_net(ans, nv_wdata_o);
    repeat (2) begin
      @(posedge clk_i);
      proj_i <= {$urandom, $urandom, $urandom};
      dl_valid_i <= 1'b1;
    end
    @(posedge clk_i);
    dl_valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    e = proj_i;
    if (m == MODE_DIRECT) e.ip[7:0] = b;
    chk_net(e, net_o);
    if (m != MODE_DIRECT) chk_net(proj_i, nv_wdata_o);
  endtask
  initial begin
    void'($urandom(32'hc100));
    foreach (TBL[i]) run(TBL[i][9:0], TBL[i][10]);
    // random bytes may hit 0 or 255 on purpose
    repeat (10) run(10'($urandom), 1'($urandom));
    finish_test();
  end
endmodule
